// >>> param_extraction_pkg.sv
// constants and types shared by the parameter extraction sequencer
package param_extraction_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ           = 100;
	localparam int DETECT_TIMEOUT_US = 10000;
	localparam int DETECT_TIMEOUT_CYC = DETECT_TIMEOUT_US * CLK_MHZ;
	localparam int TIMER_W           = 20;
	localparam int DECAY_RATIO       = 3;

	// ****************************************************************
	// open loop defaults when the normal settings are chosen
	// ****************************************************************
	localparam int OL_CURR_PCT  = 80;
	localparam int OL_SPEED_PCT = 50;
	localparam int PCT_FULL     = 100;

	// ****************************************************************
	// field widths and reset values
	// ****************************************************************
	localparam int CUR_W   = 8;
	localparam int RPT_W   = 3;
	localparam int SPD_W   = 16;
	localparam int PAR_W   = 16;
	localparam int CODE_W  = 8;
	localparam int MV_W    = 16;
	localparam logic [CUR_W-1:0] CUR_RST = 8'h00;
	localparam logic [SPD_W-1:0] SPD_RST = 16'h0000;

	// ****************************************************************
	// back-emf constant lookup, in 0.1 mV/Hz: start code, base, step
	// ****************************************************************
	localparam int SEG_N = 8;
	localparam logic [7:0] SEG_START [SEG_N] = '{8'h05, 8'h38, 8'h92, 8'h9C,
		8'hAB, 8'hD2, 8'hED, 8'hFF};
	localparam logic [15:0] SEG_BASE [SEG_N] = '{16'h0000, 16'h0069, 16'h0262,
		16'h02D0, 16'h041A, 16'h12C0, 16'h2904, 16'h4E20};
	localparam logic [15:0] SEG_STEP [SEG_N] = '{16'h0002, 16'h0005, 16'h000A,
		16'h0014, 16'h0032, 16'h00C8, 16'h01F4, 16'h0000};

	// ****************************************************************
	// sequencer states and step codes
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_DETECT = 3'b001,
		ST_ACCEL  = 3'b010,
		ST_RAMP   = 3'b011,
		ST_COAST  = 3'b100,
		ST_RUN    = 3'b101,
		ST_FAULT  = 3'b110
	} seq_state_e;

endpackage : param_extraction_pkg

// >>> bemf_const_lookup.sv
// decodes the 8-bit back-emf constant code into 0.1 mV/Hz units
`timescale 1ns/10ps
module bemf_const_lookup (
	input  wire logic                                   sys_clk,
	input  wire logic                                   reset_n,
	input  wire logic [param_extraction_pkg::CODE_W-1:0] code,
	output logic      [param_extraction_pkg::MV_W-1:0]   bemf_tenth_mv
);

	// ****************************************************************
	// piecewise table
	// ****************************************************************
	// codes below the first segment decode to zero; segment steps grow with the code, except the last segment (code FF), whose step is zero
	function automatic logic [15:0] decode(input logic [7:0] c);
		logic [15:0] v;
		logic [7:0]  d;
		v = 16'h0000;
		d = 8'h00;
		for (int i = 0; i < param_extraction_pkg::SEG_N; i++) begin
			if (c >= param_extraction_pkg::SEG_START[i]) begin
				d = c - param_extraction_pkg::SEG_START[i];
				v = param_extraction_pkg::SEG_BASE[i]
					+ 16'(d * param_extraction_pkg::SEG_STEP[i]);
			end
		end
		return v;
	endfunction : decode

	logic [15:0] mv_nxt;

	always_comb begin
		mv_nxt = decode(code);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bemf_tenth_mv <= 16'h0000;
		end else begin
			bemf_tenth_mv <= mv_nxt;
		end
	end

endmodule : bemf_const_lookup

// >>> detect_fault_monitor.sv
// watches one position detection run for timeout and slow current decay
`timescale 1ns/10ps
module detect_fault_monitor #(
	parameter int TIMEOUT_CYC = param_extraction_pkg::DETECT_TIMEOUT_CYC
) (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic detect_active,
	input  wire logic ramp_phase,
	input  wire logic decay_phase,
	output logic      fault_seen
);

	localparam int TW = param_extraction_pkg::TIMER_W;

	logic [TW-1:0] timer_r, timer_nxt;
	logic [TW-1:0] ramp_r, ramp_nxt;
	logic [TW+1:0] decay_r, decay_nxt;
	logic          fault_r, fault_nxt;

	// ****************************************************************
	// counters, cleared whenever detection is not running
	// ****************************************************************
	always_comb begin
		timer_nxt = '0;
		ramp_nxt  = '0;
		decay_nxt = '0;
		fault_nxt = 1'b0;
		if (detect_active) begin
			timer_nxt = (timer_r == TW'(TIMEOUT_CYC)) ? timer_r : timer_r + 1'b1;
			ramp_nxt  = (ramp_phase && !(&ramp_r)) ? ramp_r + 1'b1 : ramp_r;
			decay_nxt = (decay_phase && !(&decay_r)) ? decay_r + 1'b1 : decay_r;
			// decay is compared against three ramp-up lengths
			fault_nxt = (timer_r == TW'(TIMEOUT_CYC))
				|| (decay_r > (TW+2)'(ramp_r) * (TW+2)'(param_extraction_pkg::DECAY_RATIO));
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_r <= '0;
			ramp_r  <= '0;
			decay_r <= '0;
			fault_r <= 1'b0;
		end else begin
			timer_r <= timer_nxt;
			ramp_r  <= ramp_nxt;
			decay_r <= decay_nxt;
			fault_r <= fault_nxt;
		end
	end

	assign fault_seen = fault_r;

endmodule : detect_fault_monitor

// >>> param_extraction_seq.sv
// offline motor parameter extraction sequencer
// ********************************************************************
// ********************************************************************
`timescale 1ns/10ps
module param_extraction_seq #(
	parameter int DETECT_TIMEOUT_CYC = param_extraction_pkg::DETECT_TIMEOUT_CYC
) (
	input  wire logic                                  sys_clk,
	input  wire logic                                  reset_n,
	input  wire logic                                  extraction_command,
	input  wire logic [param_extraction_pkg::SPD_W-1:0] target_speed,
	input  wire logic [param_extraction_pkg::SPD_W-1:0] max_speed,
	input  wire logic                                  resistance_measure_en,
	input  wire logic                                  inductance_measure_en,
	input  wire logic                                  bemf_const_measure_en,
	input  wire logic                                  mechanical_measure_en,
	input  wire logic                                  write_shadow_en,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] winding_resistance_cfg,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] winding_inductance_cfg,
	input  wire logic [param_extraction_pkg::CODE_W-1:0] bemf_constant_code,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] speed_loop_kp_cfg,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] speed_loop_ki_cfg,
	input  wire logic                                  detect_source_select,
	input  wire logic [param_extraction_pkg::CUR_W-1:0] extract_detect_current_limit,
	input  wire logic [param_extraction_pkg::RPT_W-1:0] extract_detect_repeat,
	input  wire logic [param_extraction_pkg::CUR_W-1:0] normal_detect_current_thr,
	input  wire logic [param_extraction_pkg::RPT_W-1:0] normal_detect_repeat,
	input  wire logic                                  open_loop_param_select,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] extract_ol_slew,
	input  wire logic [param_extraction_pkg::CUR_W-1:0] extract_ol_current_ref,
	input  wire logic [param_extraction_pkg::SPD_W-1:0] extract_ol_speed_ref,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] open_loop_accel_coef1,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] open_loop_accel_coef2,
	input  wire logic [param_extraction_pkg::CUR_W-1:0] phase_current_limit,
	input  wire logic [param_extraction_pkg::MV_W-1:0]  stationary_detect_threshold,
	input  wire logic                                  fault_clear,
	input  wire logic                                  step_done,
	input  wire logic                                  detect_ramp_phase,
	input  wire logic                                  detect_decay_phase,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] resistance_est,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] inductance_est,
	input  wire logic [param_extraction_pkg::CODE_W-1:0] bemf_code_est,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] speed_kp_est,
	input  wire logic [param_extraction_pkg::PAR_W-1:0] speed_ki_est,
	input  wire logic [param_extraction_pkg::MV_W-1:0]  bemf_measured,
	output logic [2:0]                                 step_code,
	output logic                                       seq_busy,
	output logic                                       drive_hiz,
	output logic                                       normal_run_en,
	output logic [param_extraction_pkg::CUR_W-1:0]      detect_current_limit,
	output logic [param_extraction_pkg::RPT_W-1:0]      detect_repeat,
	output logic [param_extraction_pkg::PAR_W-1:0]      ol_slew_coef1,
	output logic [param_extraction_pkg::PAR_W-1:0]      ol_slew_coef2,
	output logic [param_extraction_pkg::CUR_W-1:0]      ol_current_ref,
	output logic [param_extraction_pkg::SPD_W-1:0]      ol_speed_ref,
	output logic                                       current_min_search,
	output logic                                       mech_measure_active,
	output logic                                       detect_extraction_fault,
	output logic                                       bemf_extraction_fault,
	output logic [param_extraction_pkg::PAR_W-1:0]      eff_resistance,
	output logic [param_extraction_pkg::PAR_W-1:0]      eff_inductance,
	output logic [param_extraction_pkg::CODE_W-1:0]     eff_bemf_code,
	output logic [param_extraction_pkg::MV_W-1:0]       eff_bemf_tenth_mv,
	output logic [param_extraction_pkg::PAR_W-1:0]      eff_speed_kp,
	output logic [param_extraction_pkg::PAR_W-1:0]      eff_speed_ki
);

	localparam int PW = param_extraction_pkg::PAR_W;
	localparam int CW = param_extraction_pkg::CUR_W;
	localparam int SW = param_extraction_pkg::SPD_W;

	param_extraction_pkg::seq_state_e state_r, state_nxt;

	logic gains_zero;
	logic mech_on;
	logic run_detect;
	logic run_accel;
	logic detect_fault_seen;
	logic start_req;

	// ****************************************************************
	// step conditions
	// ****************************************************************
	always_comb begin
		gains_zero = (speed_loop_kp_cfg == '0) && (speed_loop_ki_cfg == '0);
		mech_on    = mechanical_measure_en || gains_zero;
		run_detect = resistance_measure_en || inductance_measure_en
			|| (winding_resistance_cfg == '0)
			|| (winding_inductance_cfg == '0);
		run_accel  = bemf_const_measure_en || mech_on;
		start_req  = extraction_command || (target_speed != '0);
	end

	// first enabled step at or after the given one, coast always runs
	function automatic param_extraction_pkg::seq_state_e
		pick_step(input logic [1:0] from, input logic det, input logic acc,
			input logic mech);
		param_extraction_pkg::seq_state_e s;
		s = param_extraction_pkg::ST_COAST;
		if (from <= 2'd2 && mech && acc) begin
			s = param_extraction_pkg::ST_RAMP;
		end
		if (from <= 2'd1 && acc) begin
			s = param_extraction_pkg::ST_ACCEL;
		end
		if (from == 2'd0 && det) begin
			s = param_extraction_pkg::ST_DETECT;
		end
		return s;
	endfunction : pick_step

	// ****************************************************************
	// sequencer
	// ****************************************************************
	logic det_fault_r, det_fault_nxt;
	logic bemf_fault_r, bemf_fault_nxt;
	logic det_fault_set;
	logic bemf_fault_set;

	always_comb begin
		state_nxt      = state_r;
		det_fault_set  = 1'b0;
		bemf_fault_set = 1'b0;
		case (state_r)
			param_extraction_pkg::ST_IDLE: begin
				if (start_req) begin
					state_nxt = pick_step(2'd0, run_detect, run_accel, mech_on);
				end
			end
			param_extraction_pkg::ST_DETECT: begin
				if (detect_fault_seen) begin
					det_fault_set = 1'b1;
					state_nxt     = param_extraction_pkg::ST_FAULT;
				end else if (step_done) begin
					state_nxt = pick_step(2'd1, run_detect, run_accel, mech_on);
				end
			end
			param_extraction_pkg::ST_ACCEL: begin
				if (step_done) begin
					// ramp down is bypassed without mechanical measurement
					state_nxt = pick_step(2'd2, run_detect, run_accel, mech_on);
				end
			end
			param_extraction_pkg::ST_RAMP: begin
				if (step_done) begin
					state_nxt = param_extraction_pkg::ST_COAST;
				end
			end
			param_extraction_pkg::ST_COAST: begin
				if (step_done) begin
					if (bemf_measured < stationary_detect_threshold) begin
						bemf_fault_set = 1'b1;
						state_nxt      = param_extraction_pkg::ST_FAULT;
					end else if (target_speed != '0) begin
						state_nxt = param_extraction_pkg::ST_RUN;
					end else begin
						state_nxt = param_extraction_pkg::ST_IDLE;
					end
				end
			end
			param_extraction_pkg::ST_RUN: begin
				if (target_speed == '0) begin
					state_nxt = param_extraction_pkg::ST_IDLE;
				end
			end
			param_extraction_pkg::ST_FAULT: begin
				if (fault_clear && !det_fault_set && !bemf_fault_set) begin
					state_nxt = param_extraction_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = param_extraction_pkg::ST_IDLE;
			end
		endcase
		// a fault raised in the clearing cycle stays set
		det_fault_nxt  = det_fault_set || (det_fault_r && !fault_clear);
		bemf_fault_nxt = bemf_fault_set || (bemf_fault_r && !fault_clear);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r      <= param_extraction_pkg::ST_IDLE;
			det_fault_r  <= 1'b0;
			bemf_fault_r <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			det_fault_r  <= det_fault_nxt;
			bemf_fault_r <= bemf_fault_nxt;
		end
	end

	detect_fault_monitor #(
		.TIMEOUT_CYC (DETECT_TIMEOUT_CYC)
	) u_detect_mon (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.detect_active (state_r == param_extraction_pkg::ST_DETECT),
		.ramp_phase    (detect_ramp_phase),
		.decay_phase   (detect_decay_phase),
		.fault_seen    (detect_fault_seen)
	);

	// ****************************************************************
	// setting selection, registered every cycle
	// ****************************************************************
	logic [CW-1:0] det_lim_nxt, ol_cur_nxt;
	logic [2:0]    det_rpt_nxt;
	logic [PW-1:0] coef1_nxt, coef2_nxt;
	logic [SW-1:0] ol_spd_nxt;
	logic [CW+7:0] cur_prod;
	logic [SW+7:0] spd_prod;

	always_comb begin
		cur_prod = (CW+8)'(phase_current_limit) * (CW+8)'(param_extraction_pkg::OL_CURR_PCT);
		spd_prod = (SW+8)'(max_speed) * (SW+8)'(param_extraction_pkg::OL_SPEED_PCT);
		if (detect_source_select) begin
			det_lim_nxt = extract_detect_current_limit;
			det_rpt_nxt = extract_detect_repeat;
		end else begin
			det_lim_nxt = normal_detect_current_thr;
			det_rpt_nxt = normal_detect_repeat;
		end
		if (open_loop_param_select) begin
			coef1_nxt  = extract_ol_slew;
			coef2_nxt  = '0;
			ol_cur_nxt = extract_ol_current_ref;
			ol_spd_nxt = extract_ol_speed_ref;
		end else begin
			coef1_nxt  = open_loop_accel_coef1;
			coef2_nxt  = open_loop_accel_coef2;
			ol_cur_nxt = CW'(cur_prod / (CW+8)'(param_extraction_pkg::PCT_FULL));
			ol_spd_nxt = SW'(spd_prod / (SW+8)'(param_extraction_pkg::PCT_FULL));
		end
	end

	// ****************************************************************
	// effective parameters: stored zero or shadow write takes estimate
	// ****************************************************************
	logic [PW-1:0] eff_r_nxt, eff_l_nxt, eff_kp_nxt, eff_ki_nxt;
	logic [7:0]    eff_ke_nxt;

	always_comb begin
		eff_r_nxt  = (write_shadow_en || winding_resistance_cfg == '0)
			? resistance_est : winding_resistance_cfg;
		eff_l_nxt  = (write_shadow_en || winding_inductance_cfg == '0)
			? inductance_est : winding_inductance_cfg;
		eff_ke_nxt = (write_shadow_en || bemf_constant_code == '0)
			? bemf_code_est : bemf_constant_code;
		eff_kp_nxt = (write_shadow_en || speed_loop_kp_cfg == '0)
			? speed_kp_est : speed_loop_kp_cfg;
		eff_ki_nxt = (write_shadow_en || speed_loop_ki_cfg == '0)
			? speed_ki_est : speed_loop_ki_cfg;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			detect_current_limit <= param_extraction_pkg::CUR_RST;
			detect_repeat        <= '0;
			ol_slew_coef1        <= '0;
			ol_slew_coef2        <= '0;
			ol_current_ref       <= param_extraction_pkg::CUR_RST;
			ol_speed_ref         <= param_extraction_pkg::SPD_RST;
			eff_resistance       <= '0;
			eff_inductance       <= '0;
			eff_bemf_code        <= '0;
			eff_speed_kp         <= '0;
			eff_speed_ki         <= '0;
		end else begin
			detect_current_limit <= det_lim_nxt;
			detect_repeat        <= det_rpt_nxt;
			ol_slew_coef1        <= coef1_nxt;
			ol_slew_coef2        <= coef2_nxt;
			ol_current_ref       <= ol_cur_nxt;
			ol_speed_ref         <= ol_spd_nxt;
			eff_resistance       <= eff_r_nxt;
			eff_inductance       <= eff_l_nxt;
			eff_bemf_code        <= eff_ke_nxt;
			eff_speed_kp         <= eff_kp_nxt;
			eff_speed_ki         <= eff_ki_nxt;
		end
	end

	bemf_const_lookup u_ke_lookup (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.code          (eff_bemf_code),
		.bemf_tenth_mv (eff_bemf_tenth_mv)
	);

	// ****************************************************************
	// status and drive outputs
	// ****************************************************************
	// the closed loop is held off for the whole sequence so it never
	// fights the open-loop drive or the coasting measurement
	always_comb begin
		step_code          = state_r;
		seq_busy           = (state_r != param_extraction_pkg::ST_IDLE)
			&& (state_r != param_extraction_pkg::ST_RUN);
		normal_run_en      = (state_r == param_extraction_pkg::ST_RUN);
		drive_hiz          = (state_r == param_extraction_pkg::ST_COAST)
			|| (state_r == param_extraction_pkg::ST_FAULT);
		current_min_search = (state_r == param_extraction_pkg::ST_RAMP);
		mech_measure_active = (state_r == param_extraction_pkg::ST_COAST) && mech_on;
		detect_extraction_fault = det_fault_r;
		bemf_extraction_fault   = bemf_fault_r;
	end

endmodule : param_extraction_seq

// >>> param_extraction_checker.sv
// port assertions for the parameter extraction sequencer
`timescale 1ns/10ps
module param_extraction_checker (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        extraction_command,
	input wire logic [15:0] target_speed,
	input wire logic        step_done,
	input wire logic        fault_clear,
	input wire logic        detect_source_select,
	input wire logic [7:0]  extract_detect_current_limit,
	input wire logic [7:0]  normal_detect_current_thr,
	input wire logic [15:0] bemf_measured,
	input wire logic [15:0] stationary_detect_threshold,
	input wire logic [2:0]  step_code,
	input wire logic        seq_busy,
	input wire logic        drive_hiz,
	input wire logic        normal_run_en,
	input wire logic        current_min_search,
	input wire logic [7:0]  detect_current_limit,
	input wire logic        bemf_extraction_fault
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence idle_start;
		step_code == 3'h0 && (extraction_command || target_speed != 16'h0000);
	endsequence
	sequence coast_low;
		step_code == 3'h4 && step_done && bemf_measured < stationary_detect_threshold;
	endsequence
	start_req_a: assert property (idle_start |=> seq_busy)
		else $error("start request not taken");
	step_order_a: assert property ($changed(step_code) &&
		$past(step_code) inside {3'h1, 3'h2, 3'h3} |-> step_code > $past(step_code))
		else $error("extraction step went backwards");
	det_next_a: assert property (step_code == 3'h1 && step_done
		|=> step_code inside {3'h2, 3'h4, 3'h6}) else $error("ramp ran without accel");
	coast_hiz_a: assert property (step_code inside {3'h4, 3'h6} |-> drive_hiz)
		else $error("outputs driven while coasting");
	run_only_a: assert property (normal_run_en |-> step_code == 3'h5 && !seq_busy)
		else $error("normal run during extraction");
	ramp_min_a: assert property (current_min_search == (step_code == 3'h3))
		else $error("current search outside ramp");
	src_sel_a: assert property ($past(reset_n) |-> detect_current_limit ==
		$past(detect_source_select ? extract_detect_current_limit : normal_detect_current_thr))
		else $error("detect limit from wrong source");
	bemf_fault_a: assert property (coast_low |=> bemf_extraction_fault && step_code == 3'h6)
		else $error("low back-emf not flagged");
	fault_stick_a: assert property (bemf_extraction_fault && !fault_clear
		|=> bemf_extraction_fault) else $error("fault flag dropped");
endmodule : param_extraction_checker

// >>> motor_winding_model.sv
// motor and drive engine model answering each extraction step
`timescale 1ns/10ps
module motor_winding_model (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [2:0]  step_code,
	input  wire logic        drive_hiz,
	input  wire logic        hang,
	input  wire logic [15:0] bemf_level,
	output logic             step_done,
	output logic             detect_ramp_phase,
	output logic             detect_decay_phase,
	output logic [15:0]      bemf_measured
);
	logic [4:0]  age_r;
	logic [15:0] junk_r = 16'h5A5A;
	always @(posedge sys_clk) begin
		junk_r <= junk_r + 16'h3A5B;
		if (!reset_n || step_done || step_code == 3'h0 || step_code > 3'h4)
			age_r <= 5'h00;
		else
			age_r <= age_r + 5'h01;
	end
	// unequal step lengths so a stuck step code cannot hide
	assign step_done = (age_r == 5'h06 + step_code) && !(hang && step_code == 3'h1);
	assign detect_ramp_phase = step_code == 3'h1 && age_r < 5'h03;
	assign detect_decay_phase = step_code == 3'h1 && age_r >= 5'h03;
	// back-emf is only meaningful once the bridge is released
	assign bemf_measured = drive_hiz ? bemf_level : junk_r;
endmodule : motor_winding_model

// >>> tb.sv
// self-checking testbench for the parameter extraction sequencer
`timescale 1ns/10ps
module tb;
	logic sys_clk = '0, reset_n = '0, extraction_command = '0, hang = '0;
	logic resistance_measure_en = '0, inductance_measure_en = '0, write_shadow_en = '0;
	logic bemf_const_measure_en = '0, mechanical_measure_en = '0, fault_clear = '0;
	logic detect_source_select = '0, open_loop_param_select = '0;
	logic [15:0] target_speed = '0, max_speed = 16'h1001, extract_ol_slew = 16'h0123;
	logic [15:0] winding_resistance_cfg = 16'h0010, winding_inductance_cfg = 16'h0020;
	logic [15:0] speed_loop_kp_cfg = 16'h0030, speed_loop_ki_cfg = 16'h0040;
	logic [15:0] extract_ol_speed_ref = 16'h0456, open_loop_accel_coef1 = 16'h0011;
	logic [15:0] open_loop_accel_coef2 = 16'h0022, stationary_detect_threshold = 16'h0100;
	logic [15:0] resistance_est = 16'h0A01, inductance_est = 16'h0A02, bemf_level = 16'h0400;
	logic [15:0] speed_kp_est = 16'h0A03, speed_ki_est = 16'h0A04;
	logic [7:0]  bemf_constant_code = 8'h40, extract_detect_current_limit = 8'h33;
	logic [7:0]  normal_detect_current_thr = 8'h44, extract_ol_current_ref = 8'h55;
	logic [7:0]  phase_current_limit = 8'hC8, bemf_code_est = 8'h66;
	logic [2:0]  extract_detect_repeat = 3'h5, normal_detect_repeat = 3'h2;
	logic        step_done, detect_ramp_phase, detect_decay_phase, seq_busy, drive_hiz;
	logic        normal_run_en, current_min_search, mech_measure_active;
	logic        detect_extraction_fault, bemf_extraction_fault;
	logic [15:0] bemf_measured, ol_slew_coef1, ol_slew_coef2, ol_speed_ref, eff_resistance;
	logic [15:0] eff_inductance, eff_bemf_tenth_mv, eff_speed_kp, eff_speed_ki;
	logic [7:0]  detect_current_limit, ol_current_ref, eff_bemf_code;
	logic [2:0]  detect_repeat, step_code;
	int          error_cnt = 0;
	int          n_compared = 0;
	logic        mech_seen = '0;
	param_extraction_seq #(.DETECT_TIMEOUT_CYC(50)) i_param_extraction_seq (.*);
	motor_winding_model i_motor_winding_model (.*);
	always #5 sys_clk = ~sys_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	// records each new step code from idle until the stop code shows
	task automatic go(input logic [23:0] exp, input logic [2:0] stop);
		logic [23:0] tr;
		logic [2:0]  last;
		tr = '0;
		last = 3'h0;
		mech_seen = 1'b0;
		for (int i = 0; i < 400 && !(step_code === stop && tr != 0); i++) begin
			tick(1);
			extraction_command = 1'b0;
			if (step_code === 3'h4 && mech_measure_active === 1'b1)
				mech_seen = 1'b1;
			if (step_code !== last)
				tr = {tr[19:0], 1'b0, step_code};
			last = step_code;
		end
		if (step_code !== stop) begin
			error_cnt++;
			stop_test();
		end else begin
			chk(tr === exp, "step sequence");
		end
	endtask : go
	task automatic t_select;
		detect_source_select = 1'b1;
		open_loop_param_select = 1'b1;
		tick(2);
		chk(detect_current_limit === 8'h33 && detect_repeat === 3'h5, "ext detect");
		chk(ol_slew_coef1 === 16'h0123 && ol_current_ref === 8'h55, "ext slew");
		chk(ol_speed_ref === 16'h0456, "ext speed ref");
		detect_source_select = 1'b0;
		open_loop_param_select = 1'b0;
		tick(2);
		chk(detect_current_limit === 8'h44 && detect_repeat === 3'h2, "norm detect");
		chk(ol_slew_coef1 === 16'h0011 && ol_slew_coef2 === 16'h0022, "coefs");
		chk(ol_current_ref === 8'hA0 && ol_speed_ref === 16'h0800, "80/50 pct");
	endtask : t_select
	task automatic t_full;
		resistance_measure_en = 1'b1;
		bemf_const_measure_en = 1'b1;
		mechanical_measure_en = 1'b1;
		extraction_command = 1'b1;
		go(24'h012340, 3'h0);
		chk(mech_seen === 1'b1, "mech measure in coast");
		resistance_measure_en = 1'b0;
		mechanical_measure_en = 1'b0;
		extraction_command = 1'b1;
		go(24'h000240, 3'h0);
		chk(mech_seen === 1'b0, "mech measure while off");
	endtask : t_full
	task automatic t_mech_run;
		bemf_const_measure_en = 1'b0;
		speed_loop_kp_cfg = '0;
		speed_loop_ki_cfg = '0;
		target_speed = 16'h0100;
		go(24'h002345, 3'h5);
		chk(normal_run_en === 1'b1, "run after exit");
		target_speed = '0;
		tick(2);
		chk(step_code === 3'h0, "run ends");
		speed_loop_kp_cfg = 16'h0030;
		speed_loop_ki_cfg = 16'h0040;
	endtask : t_mech_run
	task automatic t_zero_cfg;
		winding_inductance_cfg = '0;
		extraction_command = 1'b1;
		go(24'h000140, 3'h0);
		winding_inductance_cfg = 16'h0020;
	endtask : t_zero_cfg
	task automatic t_faults;
		bemf_const_measure_en = 1'b1;
		bemf_level = 16'h0010;
		extraction_command = 1'b1;
		go(24'h000246, 3'h6);
		tick(3);
		chk(bemf_extraction_fault === 1'b1 && drive_hiz === 1'b1, "held off");
		fault_clear = 1'b1;
		tick(1);
		fault_clear = 1'b0;
		tick(1);
		chk(step_code === 3'h0 && bemf_extraction_fault === 1'b0, "cleared");
		bemf_level = 16'h0400;
		inductance_measure_en = 1'b1;
		hang = 1'b1;
		extraction_command = 1'b1;
		go(24'h000016, 3'h6);
		chk(detect_extraction_fault === 1'b1, "detect fault");
		fault_clear = 1'b1;
		hang = 1'b0;
		inductance_measure_en = 1'b0;
		tick(1);
		fault_clear = 1'b0;
		tick(1);
	endtask : t_faults
	task automatic t_eff;
		winding_resistance_cfg = '0;
		bemf_constant_code = 8'hFF;
		tick(3);
		chk(eff_resistance === 16'h0A01 && eff_inductance === 16'h0020, "zero cfg");
		chk(eff_bemf_tenth_mv === 16'h4E20, "code FF");
		bemf_constant_code = 8'hB0;
		tick(3);
		chk(eff_bemf_tenth_mv === 16'h0514, "code B0");
		bemf_constant_code = 8'h3F;
		tick(3);
		chk(eff_bemf_tenth_mv === 16'h008C, "code 3F");
		write_shadow_en = 1'b1;
		tick(3);
		chk(eff_speed_kp === 16'h0A03 && eff_bemf_code === 8'h66, "shadow");
		write_shadow_en = 1'b0;
		winding_resistance_cfg = 16'h0010;
	endtask : t_eff
	initial begin
		repeat (12) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		tick(1);
		t_select();
		t_full();
		t_mech_run();
		t_zero_cfg();
		t_faults();
		t_eff();
		stop_test();
	end
endmodule : tb
bind param_extraction_seq param_extraction_checker i_param_extraction_checker (.*);
